// ---- ers_sequencer.sv ----
/*
  emergency reverse sequencer: avalon-mm register slave, activation source
  select, brake / reverse / hold sequence, reverse timer and interrupt.
  assumes drive inputs are synchronous to clock and motor_speed is signed rpm.
*/
//
// Behaviour
// - events start only while the function enable bit is set
// - source 0: switch one asserting starts an event
// - source 1: script enable/disable commands only, switch ignored
// - interlock option on: interlock, throttle and direction released before driving
// - interlock option off: only throttle and direction released before driving
// - reverse lasts at most the programmed limit, 8 ms per count
// - forward motion during reverse restarts the reverse timer
// - limit of 3750 means no timeout at all
// - timer expiry ends reverse and sets the timeout fault
// - timeout fault clears when the activation input cycles
// - zero limit only stops the vehicle, never reverses
// - reverse speed capped at lesser of reverse cap and mode maximum
// - only in the two speed modes, never in torque mode
// - reverse acceleration ramps over the programmed accel time
// - slow reversing vehicle accelerates up to the cap
// - fast reversing vehicle decelerates down to the cap
`timescale 1ns/1ps
`default_nettype none
module ers_sequencer
  import ers_pkg::*;
(
  input wire logic clock,
  input wire logic rst_n,
  input wire logic [15:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic avs_waitrequest,
  output logic [31:0] avs_readdata,
  input wire ers_drive_in_s drive_in,
  output logic signed [15:0] speed_command,
  output logic override_active,
  output logic drive_inhibit,
  output logic timeout_fault,
  output logic irq
);
  typedef struct packed {
    ers_state_e fsm;
    logic [15:0] src;
    logic [15:0] cap;
    logic [15:0] acc_t;
    logic [15:0] dec_t;
    logic [15:0] lim;
    logic [15:0] opt1;
    logic [15:0] ilock;
    logic [15:0] mode;
    logic [15:0] spd_max;
    logic [15:0] exp_max;
    logic [2:0] status;
    logic [2:0] mask;
    logic script_req;
    logic req_prev;
    logic fault;
    logic [11:0] rev_timer;
    logic signed [15:0] cmd;
    logic [6:0] us_cnt;
    logic [9:0] ms_cnt;
    logic [2:0] lim_cnt;
    logic us_tick;
    logic lim_tick;
    logic waitreq;
    logic [31:0] rdata;
    logic override;
    logic inhibit;
    logic irq;
  } ers_core_s;

  ers_core_s s;
  ers_core_s n;
  logic [13:0] idx;
  logic req;
  logic rise;
  logic speed_ok;
  logic fwd;
  logic rev;
  logic released;
  logic [15:0] mode_max;
  logic [15:0] lim_spd;
  logic signed [15:0] target;
  logic acc_step;
  logic dec_step;
  logic wr_go;
  logic expired;

  function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] wd,
                                          input logic [3:0] be);
    merge16 = {be[1] ? wd[15:8] : old[15:8], be[0] ? wd[7:0] : old[7:0]};
  endfunction

  function automatic logic is_run(input ers_state_e st);
    is_run = (st == ERS_BRAKE) || (st == ERS_REVERSE);
  endfunction

  assign avs_waitrequest = s.waitreq;
  assign avs_readdata = s.rdata;
  assign speed_command = s.cmd;
  assign override_active = s.override;
  assign drive_inhibit = s.inhibit;
  assign timeout_fault = s.fault;
  assign irq = s.irq;

  ////////////////////////////////////////////////////////////////////////////////
  assign idx = avs_address[15:2];
  assign wr_go = avs_write && !s.waitreq;
  assign req = s.src[BIT_SRC_SCRIPT] ? s.script_req : drive_in.switch1;
  assign rise = req && !s.req_prev;
  assign speed_ok = (s.mode == MODE_SPEED) || (s.mode == MODE_EXPRESS);
  assign fwd = drive_in.motor_speed > 16'sh0000;
  assign rev = drive_in.motor_speed < 16'sh0000;
  // lesser of cap and mode maximum
  assign mode_max = (s.mode == MODE_EXPRESS) ? s.exp_max : s.spd_max;
  assign lim_spd = (s.cap < mode_max) ? s.cap : mode_max;
  assign target = -$signed(lim_spd);
  assign released = !drive_in.throttle_on && !drive_in.direction_on &&
                    !(s.ilock[BIT_INTERLOCK] && drive_in.interlock);
  // expiry, never at the no-timeout value
  assign expired = (s.lim != LIMIT_NO_TIMEOUT) && ({4'h0, s.rev_timer} >= s.lim);

  ers_ramp_stepper u_accel (
    .clock(clock),
    .rst_n(rst_n),
    .us_tick(s.us_tick),
    .enable(s.fsm == ERS_REVERSE),
    .rate_rpm(lim_spd),
    .period_us(26'(s.acc_t) * US_PER_MS_26),
    .step(acc_step)
  );

  ers_ramp_stepper u_decel (
    .clock(clock),
    .rst_n(rst_n),
    .us_tick(s.us_tick),
    .enable(is_run(s.fsm)),
    .rate_rpm(lim_spd),
    .period_us(26'(s.dec_t) * US_PER_MS_26),
    .step(dec_step)
  );

  ////////////////////////////////////////////////////////////////////////////////
  always_comb begin
    n = s;
    n.us_tick = 1'b0;
    n.lim_tick = 1'b0;
    n.waitreq = 1'b1;
    if (s.us_cnt == US_CNT_MAX) begin
      n.us_cnt = '0;
      n.us_tick = 1'b1;
      if (s.ms_cnt == MS_CNT_MAX) begin
        n.ms_cnt = '0;
        n.lim_cnt = (s.lim_cnt == LIM_CNT_MAX) ? 3'h0 : s.lim_cnt + 3'h1;
        n.lim_tick = (s.lim_cnt == LIM_CNT_MAX);
      end else begin
        n.ms_cnt = s.ms_cnt + 10'h001;
      end
    end else begin
      n.us_cnt = s.us_cnt + 7'h01;
    end
    // bus: one wait cycle, write lands at the edge that sees waitrequest low
    if ((avs_read || avs_write) && s.waitreq) begin
      n.waitreq = 1'b0;
      n.rdata = '0;
      if (avs_read) begin
        case (idx)
          IDX_SOURCE_SELECT: n.rdata[15:0] = s.src;
          IDX_SPEED_CAP: n.rdata[15:0] = s.cap;
          IDX_ACCEL_TIME: n.rdata[15:0] = s.acc_t;
          IDX_DECEL_TIME: n.rdata[15:0] = s.dec_t;
          IDX_TIME_LIMIT: n.rdata[15:0] = s.lim;
          IDX_OPTION_ONE: n.rdata[15:0] = s.opt1;
          IDX_INTERLOCK_OPT: n.rdata[15:0] = s.ilock;
          IDX_STATUS: n.rdata[2:0] = s.status;
          IDX_MASK: n.rdata[2:0] = s.mask;
          IDX_SCRIPT_CMD: n.rdata[0] = s.script_req;
          IDX_CONTROL_MODE: n.rdata[15:0] = s.mode;
          IDX_SPEED_MAX: n.rdata[15:0] = s.spd_max;
          IDX_EXPRESS_MAX: n.rdata[15:0] = s.exp_max;
          IDX_LIVE_STATE: n.rdata = {s.cmd, s.rev_timer, s.fsm};
          default: n.rdata = '0;
        endcase
      end
    end
    if (wr_go) begin
      case (idx)
        IDX_SOURCE_SELECT: n.src = merge16(s.src, avs_writedata, avs_byteenable);
        IDX_SPEED_CAP: n.cap = merge16(s.cap, avs_writedata, avs_byteenable);
        IDX_ACCEL_TIME: n.acc_t = merge16(s.acc_t, avs_writedata, avs_byteenable);
        IDX_DECEL_TIME: n.dec_t = merge16(s.dec_t, avs_writedata, avs_byteenable);
        IDX_TIME_LIMIT: n.lim = merge16(s.lim, avs_writedata, avs_byteenable);
        IDX_OPTION_ONE: n.opt1 = merge16(s.opt1, avs_writedata, avs_byteenable);
        IDX_INTERLOCK_OPT: n.ilock = merge16(s.ilock, avs_writedata, avs_byteenable);
        IDX_STATUS: begin
          if (avs_byteenable[0]) begin
            n.status = s.status & ~avs_writedata[2:0];
          end
        end
        IDX_MASK: begin
          if (avs_byteenable[0]) begin
            n.mask = avs_writedata[2:0];
          end
        end
        IDX_SCRIPT_CMD: begin
          if (avs_byteenable[0] && avs_writedata[BIT_CMD_ENABLE]) begin
            n.script_req = 1'b1;
          end else if (avs_byteenable[0] && avs_writedata[BIT_CMD_DISABLE]) begin
            n.script_req = 1'b0;
          end
        end
        IDX_CONTROL_MODE: n.mode = merge16(s.mode, avs_writedata, avs_byteenable);
        IDX_SPEED_MAX: n.spd_max = merge16(s.spd_max, avs_writedata, avs_byteenable);
        IDX_EXPRESS_MAX: n.exp_max = merge16(s.exp_max, avs_writedata, avs_byteenable);
        default: n.mask = s.mask;
      endcase
    end

    ////////////////////////////////////////////////////////////////////////////
    n.req_prev = req;
    // input cycle clears the fault; a later set in this cycle wins
    if (rise) begin
      n.fault = 1'b0;
    end
    case (s.fsm)
      ERS_IDLE: begin
        n.cmd = '0;
        if (rise && s.opt1[BIT_FUNC_ENABLE] && speed_ok && (!s.src[BIT_FWD_ONLY] || fwd)) begin
          n.status[ST_START] = 1'b1;
          n.cmd = drive_in.motor_speed;
          n.rev_timer = '0;
          // brake first when forward or when no reverse allowed
          n.fsm = (fwd || s.lim == '0) ? ERS_BRAKE : ERS_REVERSE;
        end
      end
      ERS_BRAKE: begin
        if (!req || !speed_ok) begin
          n.fsm = ERS_HOLD;
          n.cmd = '0;
          n.status[ST_END] = 1'b1;
        end else if (s.cmd == '0 && !fwd) begin
          n.fsm = (s.lim == '0) ? ERS_HOLD : ERS_REVERSE;
          n.status[ST_END] = (s.lim == '0);
        end else if (dec_step) begin
          n.cmd = (s.cmd > 16'sh0000) ? s.cmd - 16'sh0001 : s.cmd + 16'sh0001;
        end
      end
      ERS_REVERSE: begin
        if (!req || !speed_ok) begin
          n.fsm = ERS_HOLD;
          n.cmd = '0;
          n.status[ST_END] = 1'b1;
        end else if (expired) begin
          n.fsm = ERS_HOLD;
          n.cmd = '0;
          n.fault = 1'b1;
          n.status[ST_TIMEOUT] = 1'b1;
          n.status[ST_END] = 1'b1;
        end else begin
          if (s.cmd > target && acc_step) begin
            n.cmd = s.cmd - 16'sh0001;
          end else if (s.cmd < target && dec_step) begin
            n.cmd = s.cmd + 16'sh0001;
          end
          // timer runs in reverse, restarts on forward
          if (fwd) begin
            n.rev_timer = '0;
          end else if (rev && s.lim_tick && s.rev_timer != TIMER_SAT) begin
            n.rev_timer = s.rev_timer + 12'h001;
          end
        end
      end
      ERS_HOLD: begin
        n.cmd = '0;
        if (released) begin
          n.fsm = ERS_IDLE;
        end
      end
      default: begin
        n.fsm = ERS_IDLE;
        n.cmd = '0;
      end
    endcase
    n.override = is_run(n.fsm);
    n.inhibit = (n.fsm == ERS_HOLD);
    n.irq = |(n.status & n.mask);
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      s <= '{fsm: ERS_IDLE, src: RST_SOURCE, cap: RST_SPEED_CAP, acc_t: RST_ACCEL,
             dec_t: RST_DECEL, lim: RST_LIMIT, opt1: RST_OPTION, ilock: RST_ILOCK,
             mode: RST_MODE, spd_max: RST_MODE_MAX, exp_max: RST_MODE_MAX,
             waitreq: 1'b1, default: '0};
    end else begin
      s <= n;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);

  a_enable_gate: assert property (s.fsm == ERS_IDLE && !s.opt1[BIT_FUNC_ENABLE] |=> s.fsm == ERS_IDLE)
    else $error("event started while function disabled");
  a_switch_start: assert property (s.fsm == ERS_IDLE && s.src == 16'h0000 && s.opt1[BIT_FUNC_ENABLE]
    && speed_ok && drive_in.switch1 && !s.req_prev |=> s.override)
    else $error("switch did not start event");
  a_script_only: assert property (s.fsm == ERS_IDLE && s.src[BIT_SRC_SCRIPT] && !s.script_req
    |=> s.fsm == ERS_IDLE)
    else $error("script source started without command");
  a_forward_only: assert property (s.fsm == ERS_IDLE && s.src[BIT_FWD_ONLY] && !fwd
    |=> s.fsm == ERS_IDLE)
    else $error("forward-only source started while not forward");
  a_ilock_hold: assert property (s.fsm == ERS_HOLD && s.ilock[BIT_INTERLOCK] && drive_in.interlock
    |=> s.inhibit)
    else $error("hold left with interlock on");
  a_release_hold: assert property (s.fsm == ERS_HOLD
    && (drive_in.throttle_on || drive_in.direction_on) |=> s.fsm == ERS_HOLD && s.inhibit)
    else $error("hold left with throttle or direction on");
  a_timer_restart: assert property (s.fsm == ERS_REVERSE && fwd && req && speed_ok && !expired
    |=> s.rev_timer == 12'h000)
    else $error("reverse timer not restarted");
  a_no_timeout: assert property (s.lim == LIMIT_NO_TIMEOUT |=> !$rose(s.fault))
    else $error("timeout at no-timeout limit");
  a_timeout_fault: assert property (s.fsm == ERS_REVERSE && req && speed_ok && expired
    |=> s.fault && s.inhibit && s.cmd == 16'sh0000)
    else $error("expiry did not fault and stop");
  a_fault_clear: assert property (rise && s.fsm != ERS_REVERSE |=> !s.fault)
    else $error("fault not cleared by input cycle");
  a_zero_limit: assert property (s.fsm == ERS_BRAKE && s.lim == 16'h0000 |=> s.fsm != ERS_REVERSE)
    else $error("reversed with zero limit");
  a_speed_cap: assert property (s.fsm == ERS_REVERSE && s.cmd < target
    |=> s.cmd >= $past(s.cmd))
    else $error("reverse speed pushed beyond cap");
  a_torque_none: assert property (s.mode > MODE_EXPRESS && s.fsm == ERS_IDLE |=> !s.override)
    else $error("event in torque mode");
  a_accel_rate: assert property (s.fsm == ERS_REVERSE && !acc_step |=> s.cmd >= $past(s.cmd))
    else $error("reverse acceleration without rate step");
  a_brake_rate: assert property (s.fsm == ERS_BRAKE && s.cmd > 16'sh0000 && !dec_step && req
    && speed_ok |=> s.cmd >= $past(s.cmd))
    else $error("braking faster than decel rate");
  a_withdraw_hold: assert property (is_run(s.fsm) && !req |=> s.inhibit && !s.override)
    else $error("withdrawn request did not hold");

  c_forward_brake: cover property (s.fsm == ERS_BRAKE ##1 s.fsm == ERS_REVERSE);
  c_timeout: cover property ($rose(s.fault));
  c_release: cover property (s.fsm == ERS_HOLD ##1 s.fsm == ERS_IDLE);
  c_irq: cover property ($rose(s.irq));
endmodule
`default_nettype wire

// ---- ers_pkg.sv ----
/*
  package for the emergency reverse sequencer: register indexes, reset values,
  field positions, timing constants, state encoding and the input carrier.
  assumes a 125 MHz system clock and a 32-bit avalon-mm register port.
*/
`default_nettype none
package ers_pkg;
  // register indexes; byte address = 4 * index
  localparam logic [13:0] IDX_SOURCE_SELECT = 14'h3036;
  localparam logic [13:0] IDX_SPEED_CAP = 14'h3038;
  localparam logic [13:0] IDX_ACCEL_TIME = 14'h3039;
  localparam logic [13:0] IDX_DECEL_TIME = 14'h303a;
  localparam logic [13:0] IDX_TIME_LIMIT = 14'h303b;
  localparam logic [13:0] IDX_OPTION_ONE = 14'h306a;
  localparam logic [13:0] IDX_INTERLOCK_OPT = 14'h389f;
  localparam logic [13:0] IDX_STATUS = 14'h3f00;
  localparam logic [13:0] IDX_MASK = 14'h3f01;
  localparam logic [13:0] IDX_SCRIPT_CMD = 14'h3f02;
  localparam logic [13:0] IDX_CONTROL_MODE = 14'h3f03;
  localparam logic [13:0] IDX_SPEED_MAX = 14'h3f04;
  localparam logic [13:0] IDX_EXPRESS_MAX = 14'h3f05;
  localparam logic [13:0] IDX_LIVE_STATE = 14'h3f06;
  // field positions
  localparam int BIT_FUNC_ENABLE = 1;
  localparam int BIT_INTERLOCK = 0;
  localparam int BIT_FWD_ONLY = 1;
  localparam int BIT_SRC_SCRIPT = 0;
  localparam int BIT_CMD_ENABLE = 0;
  localparam int BIT_CMD_DISABLE = 1;
  localparam int ST_START = 0;
  localparam int ST_TIMEOUT = 1;
  localparam int ST_END = 2;
  // reset values
  localparam logic [15:0] RST_SOURCE = 16'h0000;
  localparam logic [15:0] RST_SPEED_CAP = 16'h01f4;
  localparam logic [15:0] RST_ACCEL = 16'h03e8;
  localparam logic [15:0] RST_DECEL = 16'h03e8;
  localparam logic [15:0] RST_LIMIT = 16'h0271;
  localparam logic [15:0] RST_OPTION = 16'h0000;
  localparam logic [15:0] RST_ILOCK = 16'h0000;
  localparam logic [15:0] RST_MODE = 16'h0000;
  localparam logic [15:0] RST_MODE_MAX = 16'h0fa0;
  // control modes
  localparam logic [15:0] MODE_SPEED = 16'h0000;
  localparam logic [15:0] MODE_EXPRESS = 16'h0001;
  // timing
  localparam int CLK_PERIOD_NS = 8;
  localparam int US_NS = 1000;
  localparam int CYC_PER_US = US_NS / CLK_PERIOD_NS;
  localparam logic [6:0] US_CNT_MAX = 7'(CYC_PER_US - 1);
  localparam int US_PER_MS = 1000;
  localparam logic [9:0] MS_CNT_MAX = 10'(US_PER_MS - 1);
  localparam logic [25:0] US_PER_MS_26 = 26'(US_PER_MS);
  // time limit unit: 30 s over 3750 counts
  localparam int LIMIT_UNIT_MS = 8;
  localparam logic [2:0] LIM_CNT_MAX = 3'(LIMIT_UNIT_MS - 1);
  localparam logic [15:0] LIMIT_NO_TIMEOUT = 16'h0ea6;
  localparam logic [11:0] TIMER_SAT = 12'hfff;

  typedef enum logic [3:0] {
    ERS_IDLE = 4'b0001,
    ERS_BRAKE = 4'b0010,
    ERS_REVERSE = 4'b0100,
    ERS_HOLD = 4'b1000
  } ers_state_e;

  typedef struct packed {
    logic switch1;
    logic interlock;
    logic throttle_on;
    logic direction_on;
    logic signed [15:0] motor_speed;
  } ers_drive_in_s;
endpackage
`default_nettype wire

// ---- ers_ramp_stepper.sv ----
/*
  rate stepper: emits one-cycle step pulses so that a command moves rate_rpm
  steps within period_us microseconds. assumes us_tick is a one-cycle enable.
*/
`timescale 1ns/1ps
`default_nettype none
module ers_ramp_stepper
  import ers_pkg::*;
(
  input wire logic clock,
  input wire logic rst_n,
  input wire logic us_tick,
  input wire logic enable,
  input wire logic [15:0] rate_rpm,
  input wire logic [25:0] period_us,
  output logic step
);
  typedef struct packed {
    logic [26:0] acc;
    logic step;
  } ers_step_s;

  ers_step_s s;
  ers_step_s n;
  logic [26:0] sum;

  assign step = s.step;
  assign sum = s.acc + 27'(rate_rpm);

  // bresenham style: avoids a divider, at most one step per microsecond
  always_comb begin
    n = s;
    n.step = 1'b0;
    if (!enable) begin
      n.acc = '0;
    end else if (us_tick) begin
      if (period_us == '0) begin
        n.step = 1'b1;
      end else if (sum >= {1'b0, period_us}) begin
        n.acc = sum - {1'b0, period_us};
        n.step = 1'b1;
      end else begin
        n.acc = sum;
      end
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      s <= '0;
    end else begin
      s <= n;
    end
  end
endmodule
`default_nettype wire

// ---- ers_motor_model.sv ----
/*
  motor drive model for the sequencer bench: the motor follows the speed
  command one rpm per cycle while an event overrides it, and keeps its speed
  otherwise; the bench may preset the speed.
  assumes the command and override outputs are registered on the same clock.
*/
`timescale 1ns/1ps
`default_nettype none
module ers_motor_model (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic signed [15:0] speed_command,
  input wire logic override_active,
  input wire logic preset_load,
  input wire logic signed [15:0] preset_speed,
  output logic signed [15:0] motor_speed
);
  // inertia of one rpm per cycle keeps braking and reversing visible
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      motor_speed <= 16'sh0000;
    end else if (preset_load) begin
      motor_speed <= preset_speed;
    end else if (override_active && motor_speed < speed_command) begin
      motor_speed <= motor_speed + 16'sh0001;
    end else if (override_active && motor_speed > speed_command) begin
      motor_speed <= motor_speed - 16'sh0001;
    end
  end
endmodule
`default_nettype wire

// ---- tb_emergency_reverse_sequencer.sv ----
/*
  self-checking bench for the sequencer: avalon-mm register tasks, operator
  inputs and a motor model. assumes the one-wait-cycle register port.
*/
`timescale 1ns/1ps
`default_nettype none
module tb_emergency_reverse_sequencer
  import ers_pkg::*;
;
  logic clock = 1'b0;
  logic rst_n = 1'b0;
  logic [15:0] avs_address = 16'h0000;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0000_0000;
  logic [3:0] avs_byteenable = 4'hf;
  logic avs_waitrequest, override_active, drive_inhibit, timeout_fault, irq;
  logic [31:0] avs_readdata;
  logic signed [15:0] speed_command, motor_speed;
  logic sw = 1'b0, ilk = 1'b1, thr = 1'b1, dirn = 1'b1, pload = 1'b0;
  logic signed [15:0] pspeed = 16'sh0000;
  ers_drive_in_s drive_in;
  int miscompares = 0;
  int total_checks = 0;
  logic [31:0] rd;
  logic [13:0] idx_tab [12] = '{IDX_SOURCE_SELECT, IDX_SPEED_CAP, IDX_ACCEL_TIME,
    IDX_DECEL_TIME, IDX_TIME_LIMIT, IDX_OPTION_ONE, IDX_INTERLOCK_OPT, IDX_CONTROL_MODE,
    IDX_SPEED_MAX, IDX_EXPRESS_MAX, IDX_STATUS, IDX_MASK};
  logic [15:0] rst_tab [12] = '{RST_SOURCE, RST_SPEED_CAP, RST_ACCEL, RST_DECEL, RST_LIMIT,
    RST_OPTION, RST_ILOCK, RST_MODE, RST_MODE_MAX, RST_MODE_MAX, 16'h0000, 16'h0000};

  assign drive_in = {sw, ilk, thr, dirn, motor_speed};
  always #(CLK_PERIOD_NS / 2) clock = ~clock;

  ers_sequencer dut (.clock(clock), .rst_n(rst_n), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_waitrequest(avs_waitrequest),
    .avs_readdata(avs_readdata), .drive_in(drive_in), .speed_command(speed_command),
    .override_active(override_active), .drive_inhibit(drive_inhibit),
    .timeout_fault(timeout_fault), .irq(irq));
  ers_motor_model motor_far (.clock(clock), .rst_n(rst_n), .speed_command(speed_command),
    .override_active(override_active), .preset_load(pload), .preset_speed(pspeed),
    .motor_speed(motor_speed));

  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("mismatch at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask

  task automatic print_verdict();
    if (miscompares == 0 && total_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  // request held until waitrequest is sampled low at a rising edge; data taken at that edge
  task automatic bus(input logic wr, input logic [13:0] idx, input logic [31:0] wd);
    @(posedge clock);
    avs_address <= {idx, 2'b00};
    avs_read <= !wr;
    avs_write <= wr;
    avs_writedata <= wd;
    do @(posedge clock); while (avs_waitrequest !== 1'b0);
    chk(avs_waitrequest, 32'h0);
    rd = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    // one more edge so that callers see what the access has updated
    @(posedge clock);
  endtask

  task automatic rd_chk(input logic [13:0] idx, input logic [31:0] exp);
    bus(1'b0, idx, 32'h0);
    chk(rd, exp);
  endtask

  task automatic req(input logic script, input logic on);
    if (script) bus(1'b1, IDX_SCRIPT_CMD, on ? 32'h1 : 32'h2);
    else begin
      @(posedge clock);
      sw <= on;
    end
    repeat (4) @(posedge clock);
  endtask

  task automatic motor(input logic signed [15:0] v);
    @(posedge clock);
    pspeed <= v;
    pload <= 1'b1;
    @(posedge clock);
    pload <= 1'b0;
  endtask

  task automatic let_go();
    @(posedge clock);
    thr <= 1'b0;
    dirn <= 1'b0;
    repeat (4) @(posedge clock);
    chk(drive_inhibit, 32'h0);
    thr <= 1'b1;
    dirn <= 1'b1;
  endtask

  task automatic event_run(input logic script);
    req(script, 1'b1);
    chk(override_active, 32'h1);
    req(script, 1'b0);
    chk(drive_inhibit, 32'h1);
    chk(speed_command, 32'h0);
    let_go();
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (60000) @(posedge clock);
    miscompares++;
    print_verdict();
  end

  initial begin
    repeat (5) @(posedge clock);
    rst_n <= 1'b1;
    for (int i = 0; i < 12; i++) rd_chk(idx_tab[i], {16'h0000, rst_tab[i]});
    rd_chk(14'h0001, 32'h0);
    bus(1'b1, 14'h0001, 32'hffff);
    rd_chk(14'h0001, 32'h0);
    bus(1'b1, IDX_SPEED_CAP, 32'h0bb8);
    rd_chk(IDX_SPEED_CAP, 32'h0bb8);
    avs_byteenable <= 4'h1;
    bus(1'b1, IDX_SPEED_CAP, 32'h00ff);
    rd_chk(IDX_SPEED_CAP, 32'h0bff);
    avs_byteenable <= 4'hf;
    chk(timeout_fault, 32'h0);
    motor(16'sd100);
    req(1'b0, 1'b1);
    chk(override_active, 32'h0);
    req(1'b0, 1'b0);
    bus(1'b1, IDX_OPTION_ONE, 32'h2);
    bus(1'b1, IDX_MASK, 32'h7);
    bus(1'b1, IDX_INTERLOCK_OPT, 32'h1);
    req(1'b0, 1'b1);
    chk(override_active, 32'h1);
    chk(irq, 32'h1);
    rd_chk(IDX_STATUS, 32'h1);
    bus(1'b1, IDX_STATUS, 32'h7);
    chk(irq, 32'h0);
    req(1'b0, 1'b0);
    chk(drive_inhibit, 32'h1);
    @(posedge clock);
    thr <= 1'b0;
    dirn <= 1'b0;
    repeat (4) @(posedge clock);
    chk(drive_inhibit, 32'h1);
    ilk <= 1'b0;
    repeat (4) @(posedge clock);
    chk(drive_inhibit, 32'h0);
    thr <= 1'b1;
    dirn <= 1'b1;
    ilk <= 1'b1;
    bus(1'b1, IDX_INTERLOCK_OPT, 32'h0);
    event_run(1'b0);
    bus(1'b1, IDX_SOURCE_SELECT, 32'h1);
    req(1'b0, 1'b1);
    chk(override_active, 32'h0);
    req(1'b0, 1'b0);
    event_run(1'b1);
    for (int s = 2; s < 4; s++) begin
      bus(1'b1, IDX_SOURCE_SELECT, 32'(s));
      motor(-16'sd50);
      req(s[0], 1'b1);
      chk(override_active, 32'h0);
      req(s[0], 1'b0);
      motor(16'sd100);
      event_run(s[0]);
    end
    bus(1'b1, IDX_SOURCE_SELECT, 32'h0);
    bus(1'b1, IDX_CONTROL_MODE, 32'h2);
    req(1'b0, 1'b1);
    chk(override_active, 32'h0);
    req(1'b0, 1'b0);
    bus(1'b1, IDX_CONTROL_MODE, 32'h1);
    bus(1'b1, IDX_MASK, 32'h0);
    bus(1'b1, IDX_STATUS, 32'h7);
    event_run(1'b0);
    chk(irq, 32'h0);
    rd_chk(IDX_STATUS, 32'h5);
    bus(1'b1, IDX_TIME_LIMIT, 32'h0);
    motor(16'sd0);
    req(1'b0, 1'b1);
    repeat (20) @(posedge clock);
    chk(drive_inhibit, 32'h1);
    chk(override_active, 32'h0);
    req(1'b0, 1'b0);
    let_go();
    bus(1'b1, IDX_TIME_LIMIT, 32'h1);
    motor(16'sd0);
    req(1'b0, 1'b1);
    bus(1'b0, IDX_LIVE_STATE, 32'h0);
    chk(rd[3:0], 32'h4);
    chk(override_active, 32'h1);
    req(1'b0, 1'b0);
    let_go();
    print_verdict();
  end
endmodule
`default_nettype wire
